// File: bench/sprt_partner.sv
`default_nettype none
module sprt_partner
(
  // bench control
  input wire logic i_clock,
  input wire logic i_run,
  input wire logic [2:0] i_drive,
  input wire logic [2:0] i_level,
  // device side of receive pins: clock, data, sync
  input wire logic [2:0] i_dev_out,
  input wire logic [2:0] i_dev_oe_n,
  // resolved levels
  output logic [2:0] o_wire,
  output logic o_tx_clock
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // far-side serial device
  // ----
  logic ext_clk = 1'h0;
  logic flip = 1'h0;
  logic [2:0] src;

  // 90 ns period stays under the 50 MHz / 2.6 limit; still between bursts
  always #45 ext_clk = i_run ? ~ext_clk : 1'h0;
  // an undriven line wanders so no stale level can pass for a real one
  always @(posedge i_clock) flip <= ~flip;
  assign src = {i_level[2:1], i_run ? ext_clk : i_level[0]};
  assign o_tx_clock = i_run ? ext_clk : 1'h0;

  always_comb
  begin
    for (int k = 0; k < 3; k++)
      o_wire[k] = !i_dev_oe_n[k] ? i_dev_out[k] : (i_drive[k] ? src[k] : flip);
  end
endmodule : sprt_partner
`default_nettype wire

// File: bench/sprt_properties.sv
`default_nettype none
module sprt_checker
  import sprt_pkg::*;
#(
  parameter int CNT_W = SPRT_CNT_W
)
(
  // clock, reset and register port
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic [SPRT_ADDR_W-1:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  // pins and timer outputs
  input wire logic o_rx_clock_pin,
  input wire logic o_rx_clock_pin_oe_n,
  input wire logic o_rx_data_pin_oe_n,
  input wire logic o_rx_sync_pin,
  input wire logic o_rx_sync_pin_oe_n,
  input wire logic o_tx_timer_out,
  input wire logic o_tx_timer_irq,
  input wire logic o_rx_timer_irq
);
  // ----
  // shadow of the transmit timer mode, only the port is visible here
  // ----
  wire logic pin_wr = i_wr && (i_addr == SPRT_OFS_PINCTL);
  wire logic ctl_wr = i_wr && (i_addr == SPRT_OFS_TIMCTL);
  logic tx_cp;
  logic tx_run;
  logic rx_ser;

  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      tx_cp <= 1'h0;
      tx_run <= 1'h0;
    end
    else if (ctl_wr)
    begin
      tx_cp <= i_wdata[2];
      tx_run <= i_wdata[1];
    end
  end

  // receive clock pin in serial mode carries the receive timer flag
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
      rx_ser <= 1'h0;
    else if (pin_wr)
      rx_ser <= i_wdata[0];
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_srst);

  a_reset_quiet:
    assert property ($past(i_srst) |-> o_rdata == 32'h0 && o_rx_clock_pin_oe_n
      && o_rx_data_pin_oe_n && o_rx_sync_pin_oe_n && !o_tx_timer_out && !o_tx_timer_irq
      && !o_rx_timer_irq)
    else $error("outputs not quiet after reset");
  a_pin_reserved:
    assert property ($past(i_rd) && $past(i_addr) == SPRT_OFS_PINCTL |-> o_rdata[31:12] == 20'h0)
    else $error("pin control reserved bits not zero");
  a_ctl_reserved:
    assert property ($past(i_rd) && $past(i_addr) == SPRT_OFS_TIMCTL
      |-> {o_rdata[31:12], o_rdata[10], o_rdata[4]} == 22'h0)
    else $error("timer control reserved bits not zero");
  a_data_pin_mode:
    assert property ($past(pin_wr, 2)
      |-> o_rx_data_pin_oe_n == ($past(i_wdata[4], 2) || !$past(i_wdata[5], 2)))
    else $error("data pin drive wrong");
  a_sync_pin_level:
    assert property ($past(pin_wr, 2)
      |-> o_rx_sync_pin_oe_n == ($past(i_wdata[8], 2) || !$past(i_wdata[9], 2))
      && (o_rx_sync_pin_oe_n || o_rx_sync_pin == $past(i_wdata[10], 2)))
    else $error("sync pin drive wrong");
  a_clock_pin_gpio:
    assert property ($past(pin_wr, 2) && !$past(i_wdata[0], 2)
      |-> o_rx_clock_pin_oe_n == !$past(i_wdata[1], 2)
      && (o_rx_clock_pin_oe_n || o_rx_clock_pin == $past(i_wdata[2], 2)))
    else $error("clock pin drive wrong");
  a_irq_on_rise:
    assert property ($rose(o_tx_timer_out) |-> o_tx_timer_irq)
    else $error("no request after flag rise");
  a_irq_cause:
    assert property (o_tx_timer_irq |-> o_tx_timer_out && !$past(o_tx_timer_out))
    else $error("request without flag rise");
  a_pulse_single:
    assert property (!tx_cp && $rose(o_tx_timer_out) |=> !o_tx_timer_out)
    else $error("pulse longer than one cycle");
  a_hold_frozen:
    assert property (!tx_run && !$past(tx_run) && !$past(tx_run, 2) |-> $stable(o_tx_timer_out))
    else $error("held timer output moved");
  a_flag_visible:
    assert property ($past(i_rd) && $past(i_addr) == SPRT_OFS_TIMCTL
      |-> o_rdata[5] == $past(o_tx_timer_out))
    else $error("status bit differs from timer output");
  a_rx_irq_pin:
    assert property ($past(rx_ser) && $past(rx_ser, 2) && $rose(o_rx_clock_pin)
      |-> $past(o_rx_timer_irq))
    else $error("receive timer rise without request");

  c_tx_pulse: cover property ($rose(o_tx_timer_out));
  c_held_write: cover property (!tx_run && ctl_wr);
  c_gpio_drive: cover property (!o_rx_sync_pin_oe_n && o_rx_sync_pin);
endmodule : sprt_checker

bind sprt_top sprt_checker #(.CNT_W(CNT_W)) u_chk (.i_clock, .i_srst, .i_addr, .i_wdata,
  .i_wr, .i_rd, .o_rdata, .o_rx_clock_pin, .o_rx_clock_pin_oe_n, .o_rx_data_pin_oe_n,
  .o_rx_sync_pin, .o_rx_sync_pin_oe_n, .o_tx_timer_out, .o_tx_timer_irq, .o_rx_timer_irq);
`default_nettype wire

// File: bench/sprt_top_tb.sv
`default_nettype none
module sprt_top_tb
  import sprt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // bench
  // ----
  logic i_clock = 1'h0;
  logic i_srst = 1'h1;
  logic [7:0] i_addr = 8'h0;
  logic [31:0] i_wdata = 32'h0;
  logic i_wr = 1'h0;
  logic i_rd = 1'h0;
  logic [31:0] o_rdata;
  logic [2:0] pin_out, pin_oe_n, pin_wire;
  logic [2:0] drive = 3'h7;
  logic [2:0] level = 3'h0;
  logic run = 1'h0;
  logic tx_clk, o_tx_timer_out, o_tx_timer_irq, o_rx_timer_irq;
  logic rd_seen = 1'h0;
  logic [63:0] note;
  logic [63:0] exp_q[$];
  int n_fail = 0;
  int num_checks = 0;
  int seed = 32'h2C49E982;
  logic [7:0] ofs[5] = '{SPRT_OFS_PINCTL, SPRT_OFS_TIMCTL, SPRT_OFS_COUNT, SPRT_OFS_PERIOD, 8'h10};

  always #10 i_clock = ~i_clock;

  sprt_top uut (.i_clock, .i_srst, .i_clk_en(1'h1), .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_rx_clock_pin(pin_wire[0]), .o_rx_clock_pin(pin_out[0]), .o_rx_clock_pin_oe_n(pin_oe_n[0]),
    .i_rx_data_pin(pin_wire[1]), .o_rx_data_pin(pin_out[1]), .o_rx_data_pin_oe_n(pin_oe_n[1]),
    .i_rx_sync_pin(pin_wire[2]), .o_rx_sync_pin(pin_out[2]), .o_rx_sync_pin_oe_n(pin_oe_n[2]),
    .i_tx_clock_pin(tx_clk), .o_tx_timer_out, .o_tx_timer_irq, .o_rx_timer_irq);

  sprt_partner u_far (.i_clock, .i_run(run), .i_drive(drive), .i_level(level),
    .i_dev_out(pin_out), .i_dev_oe_n(pin_oe_n), .o_wire(pin_wire), .o_tx_clock(tx_clk));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : test_done

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'h1;
    @(posedge i_clock);
    i_wr <= 1'h0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge i_clock);
    i_addr <= a;
    i_rd <= 1'h1;
    exp_q.push_back({e, m});
    @(posedge i_clock);
    i_rd <= 1'h0;
  endtask : rd_reg

  task automatic do_reset();
    i_srst <= 1'h1;
    repeat (20) @(posedge i_clock);
    i_srst <= 1'h0;
  endtask : do_reset

  // every place, an unmapped one too, must read zero after reset
  task automatic rd_zero();
    foreach (ofs[i])
      rd_reg(ofs[i], 32'h0, 32'hFFFFFFFF);
  endtask : rd_zero

  // cycles between two rising edges of the chosen timer output
  task automatic interval(input logic sel, output int iv);
    int t0;
    logic prev;
    logic cur;
    t0 = -1;
    iv = 0;
    prev = sel ? pin_out[0] : o_tx_timer_out;
    for (int n = 0; n < 400; n++)
    begin
      @(posedge i_clock);
      cur = sel ? pin_out[0] : o_tx_timer_out;
      if (cur && !prev && t0 >= 0)
      begin
        iv = n - t0;
        return;
      end
      if (cur && !prev)
        t0 = n;
      prev = cur;
    end
    n_fail++;
    test_done();
  endtask : interval

  // read data stand one cycle after the strobe, so the note is taken then
  always @(posedge i_clock)
  begin
    rd_seen <= i_rd;
    if (rd_seen && exp_q.size() > 0)
    begin
      note = exp_q.pop_front();
      check(o_rdata & note[31:0], note[63:32] & note[31:0]);
    end
  end

  initial
  begin
    logic [31:0] r;
    logic [31:0] e;
    logic [31:0] m;
    int iv;
    do_reset();
    wr_reg(8'h10, 32'hFFFFFFFF);
    rd_zero();
    for (int i = 0; i < 8; i++)
    begin
      r = $random(seed);
      drive <= r[30:28];
      level <= r[26:24];
      wr_reg(SPRT_OFS_PINCTL, r);
      e = r & 32'h777;
      m = 32'hFFFFFFFF;
      // the input bit follows our own drive, the far side, or nobody
      for (int k = 0; k < 3; k++)
        if (!r[4*k] && r[4*k+1])
          e[4*k+3] = r[4*k+2];
        else if (r[28+k])
          e[4*k+3] = r[24+k];
        else
          m[4*k+3] = 1'h0;
      repeat (5) @(posedge i_clock);
      rd_reg(SPRT_OFS_PINCTL, e, m);
    end
    wr_reg(SPRT_OFS_PINCTL, 32'h1);
    wr_reg(SPRT_OFS_PERIOD, 32'h0005_0003);
    wr_reg(SPRT_OFS_TIMCTL, 32'h3CB);
    repeat (2) @(posedge i_clock);
    rd_reg(SPRT_OFS_TIMCTL, 32'h38A, 32'hFFFFF7DF);
    interval(1'h0, iv);
    check(iv, 6);
    interval(1'h1, iv);
    check(iv, 20);
    wr_reg(SPRT_OFS_TIMCTL, 32'h300);
    wr_reg(SPRT_OFS_COUNT, 32'h0004_0002);
    wr_reg(SPRT_OFS_PERIOD, 32'h0009_0007);
    repeat (10) @(posedge i_clock);
    rd_reg(SPRT_OFS_COUNT, 32'h0004_0002, 32'hFFFFFFFF);
    rd_reg(SPRT_OFS_PERIOD, 32'h0009_0007, 32'hFFFFFFFF);
    run <= 1'h1;
    drive <= 3'h7;
    wr_reg(SPRT_OFS_PERIOD, 32'h0002_0002);
    wr_reg(SPRT_OFS_TIMCTL, 32'hC3);
    interval(1'h0, iv);
    check(32'(iv >= 8 && iv <= 10), 32'h1);
    // the receive timer counts the far side's clock on its own pin, pulse mode
    iv = 0;
    repeat (180)
    begin
      @(posedge i_clock);
      iv += o_rx_timer_irq;
    end
    check(32'(iv >= 19 && iv <= 21), 32'h1);
    wr_reg(SPRT_OFS_TIMCTL, 32'h0);
    run <= 1'h0;
    drive <= 3'h7;
    level <= 3'h0;
    do_reset();
    rd_zero();
    repeat (2) @(posedge i_clock);
    test_done();
  end
endmodule : sprt_top_tb
`default_nettype wire

// File: hw/sprt_timer.sv
`default_nettype none
module sprt_timer
  import sprt_pkg::*;
#(
  parameter int CNT_W = SPRT_CNT_W
)
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic i_clk_en,
  // control
  input wire sprt_tctl_t i_ctl,
  input wire logic i_ext_clk,
  input wire logic [CNT_W-1:0] i_period,
  input wire logic i_cnt_wr,
  input wire logic [CNT_W-1:0] i_cnt_wdata,
  // state
  output logic [CNT_W-1:0] o_count,
  output logic o_flag,
  output logic o_go_done,
  output logic o_irq
);

  logic prescale;
  logic ext_prev;
  logic tick;
  logic step;
  logic wrap;
  logic next_flag;
  logic [CNT_W-1:0] next_count;

  // ---------------------------------------------------------------
  // input clock select
  // ---------------------------------------------------------------
  always_comb
  begin
    tick = i_ctl.src_sel ? prescale : (i_ext_clk & ~ext_prev);
    step = i_ctl.run_n_hold & tick;
    next_count = o_count + CNT_W'(1);
    wrap = step & ~i_ctl.go & (next_count == i_period);
    o_go_done = step & i_ctl.go;
  end

  // prescaler stops with the counter so a resume continues mid-cycle
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
      prescale <= 1'b0;
    else if (i_clk_en && i_ctl.run_n_hold)
      prescale <= ~prescale;
  end

  always_ff @(posedge i_clock)
  begin
    if (i_srst)
      ext_prev <= 1'b0;
    else if (i_clk_en)
      ext_prev <= i_ext_clk;
  end

  // ---------------------------------------------------------------
  // counter
  // ---------------------------------------------------------------
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
      o_count <= '0;
    else if (i_clk_en)
    begin
      if (i_cnt_wr)
        o_count <= i_cnt_wdata;
      else if (o_go_done || wrap)
        o_count <= '0;
      else if (step)
        o_count <= next_count;
    end
  end

  // ---------------------------------------------------------------
  // status flag and rising-edge request
  // ---------------------------------------------------------------
  always_comb
  begin
    next_flag = o_flag;
    if (o_go_done)
      next_flag = 1'b0;
    else if (wrap)
      next_flag = i_ctl.clock_pulse_sel ? ~o_flag : 1'b1;
    else if (!i_ctl.clock_pulse_sel)
      next_flag = 1'b0;
  end

  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      o_flag <= 1'b0;
      o_irq <= 1'b0;
    end
    else if (i_clk_en)
    begin
      o_flag <= next_flag;
      o_irq <= next_flag & ~o_flag;
    end
  end

endmodule : sprt_timer
`default_nettype wire

// File: hw/sprt_top.sv
//
// Contract
// - func_sel bit per receive pin: 0 general I/O, 1 serial pin.
// - in general mode, dir bit 0 makes pin input, 1 output.
// - data-out bit sets level driven while pin is general output.
// - data-in bit shows sampled pin level; writes ignored.
// - pin control and timer control registers clear to zero on reset.
// - timer control bits 5-0 transmit timer, 11-6 receive timer.
// - transmit go zeroes counter, starts on next input edge, self-clears.
// - writing 0 to a go bit does nothing.
// - hold bit 0 freezes counter and prescaler; 1 resumes.
// - timer registers stay readable and writable while held.
// - reset overrides hold and clears the timer.
// - clock mode: flag and output toggle, 50 percent duty.
// - pulse mode: flag and output high one clock per period.
// - source 1 counts at half the processor clock.
// - source 0 counts edges of transmit or receive clock pin.
// - external timer clock synchronised; must stay below reference/2.6.
// - status flag read-only, tracks uninverted timer output.
// - flag rising edge raises an interrupt request.
// - receive go zeroes and starts receive counter, self-clears.
// - 16-bit counters wrap to 0 on reaching period; reset clears.
// - period register: transmit low half, receive high half.
//
// Implementation choices: strobed register access and the register addresses.
`default_nettype none
module sprt_top
  import sprt_pkg::*;
#(
  parameter int CNT_W = SPRT_CNT_W
)
(
  // clock, reset, enable
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic i_clk_en,
  // register port
  input wire logic [SPRT_ADDR_W-1:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // receive clock pin
  input wire logic i_rx_clock_pin,
  output logic o_rx_clock_pin,
  output logic o_rx_clock_pin_oe_n,
  // receive data pin
  input wire logic i_rx_data_pin,
  output logic o_rx_data_pin,
  output logic o_rx_data_pin_oe_n,
  // receive frame sync pin
  input wire logic i_rx_sync_pin,
  output logic o_rx_sync_pin,
  output logic o_rx_sync_pin_oe_n,
  // transmit clock pin, used as timer source only
  input wire logic i_tx_clock_pin,
  // timer outputs
  output logic o_tx_timer_out,
  output logic o_tx_timer_irq,
  output logic o_rx_timer_irq
);

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  // counters share one word in halves, so they cannot exceed a half
  if (CNT_W < 2 || CNT_W > SPRT_HALF_W)
  begin : g_bad_cnt_w
    $error("sprt_top: CNT_W must be 2..16");
  end

  // the packed field views feed the read port directly, so they must match
  if ($bits(sprt_pin_t) != SPRT_PIN_FLD_W || $bits(sprt_tctl_t) != SPRT_TIM_FLD_W)
  begin : g_bad_fields
    $error("sprt_top: field structs do not match field widths");
  end

  // every field of one register must fit the 32-bit word
  if (SPRT_NUM_PINS * SPRT_PIN_FLD_W > 32 || SPRT_NUM_TIMERS * SPRT_TIM_FLD_W > 32)
  begin : g_bad_map
    $error("sprt_top: register fields exceed 32 bits");
  end

  // the transmit clock rides on the synchroniser beside the receive pins
  if (SPRT_SYNC_W != SPRT_NUM_PINS + 1 || SPRT_SYNC_TXCLK != SPRT_NUM_PINS)
  begin : g_bad_sync
    $error("sprt_top: synchroniser width does not match pin count");
  end

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [SPRT_SYNC_W-1:0] pin_meta;
  logic [SPRT_SYNC_W-1:0] pin_sync;
  logic [SPRT_SYNC_W-1:0] pin_raw;
  sprt_pin_t [SPRT_NUM_PINS-1:0] pinctl;
  sprt_tctl_t [SPRT_NUM_TIMERS-1:0] timctl;
  sprt_tctl_t [SPRT_NUM_TIMERS-1:0] tim_view;
  logic [SPRT_NUM_TIMERS-1:0][CNT_W-1:0] period;
  logic [SPRT_NUM_TIMERS-1:0][CNT_W-1:0] count;
  logic [SPRT_NUM_TIMERS-1:0] flag;
  logic [SPRT_NUM_TIMERS-1:0] go_done;
  logic [SPRT_NUM_TIMERS-1:0] irq;
  logic [SPRT_NUM_TIMERS-1:0] ext_clk;
  logic wr_pinctl;
  logic wr_timctl;
  logic wr_count;
  logic wr_period;
  logic [31:0] next_rdata;
  logic next_clk_drive;
  logic next_clk_level;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic reg_hit(
    input logic [SPRT_ADDR_W-1:0] addr,
    input logic [7:0] ofs
  );
    reg_hit = (addr == ofs);
  endfunction : reg_hit

  function automatic logic [SPRT_HALF_W-1:0] widen(
    input logic [CNT_W-1:0] val
  );
    widen = SPRT_HALF_W'(val);
  endfunction : widen

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  always_comb
  begin
    wr_pinctl = i_wr & reg_hit(i_addr, SPRT_OFS_PINCTL);
    wr_timctl = i_wr & reg_hit(i_addr, SPRT_OFS_TIMCTL);
    wr_count = i_wr & reg_hit(i_addr, SPRT_OFS_COUNT);
    wr_period = i_wr & reg_hit(i_addr, SPRT_OFS_PERIOD);
  end

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  // every pin is asynchronous to i_clock; the external timer clock
  // must stay well below the clock rate for these to see each edge
  always_comb
  begin
    pin_raw[SPRT_PIN_CLK] = i_rx_clock_pin;
    pin_raw[SPRT_PIN_DATA] = i_rx_data_pin;
    pin_raw[SPRT_PIN_SYNC] = i_rx_sync_pin;
    pin_raw[SPRT_SYNC_TXCLK] = i_tx_clock_pin;
  end

  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      pin_meta <= '0;
      pin_sync <= '0;
    end
    else if (i_clk_en)
    begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
    end
  end

  always_comb
  begin
    ext_clk[SPRT_TX] = pin_sync[SPRT_SYNC_TXCLK];
    ext_clk[SPRT_RX] = pin_sync[SPRT_PIN_CLK];
  end

  // ---------------------------------------------------------------
  // receive pin control register
  // ---------------------------------------------------------------
  generate
    for (genvar p = 0; p < SPRT_NUM_PINS; p++)
    begin : g_pin
      localparam int F = p * SPRT_PIN_FLD_W;

      always_ff @(posedge i_clock)
      begin
        if (i_srst)
          pinctl[p] <= sprt_pin_t'(SPRT_RST_PINCTL[F +: SPRT_PIN_FLD_W]);
        else if (i_clk_en)
        begin
          // the data-in position holds the live sampled level instead
          pinctl[p].dat_in <= pin_sync[p];
          if (wr_pinctl)
          begin
            pinctl[p].func_sel <= i_wdata[F];
            pinctl[p].dir <= i_wdata[F+1];
            pinctl[p].dat_out <= i_wdata[F+2];
          end
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // pin drivers
  // ---------------------------------------------------------------
  // in serial mode the clock pin carries the receive timer output
  // only when that timer runs from the internal source
  always_comb
  begin
    if (pinctl[SPRT_PIN_CLK].func_sel)
    begin
      next_clk_drive = timctl[SPRT_RX].src_sel;
      next_clk_level = flag[SPRT_RX];
    end
    else
    begin
      next_clk_drive = pinctl[SPRT_PIN_CLK].dir;
      next_clk_level = pinctl[SPRT_PIN_CLK].dat_out;
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      o_rx_clock_pin <= 1'b0;
      o_rx_clock_pin_oe_n <= 1'b1;
      o_rx_data_pin <= 1'b0;
      o_rx_data_pin_oe_n <= 1'b1;
      o_rx_sync_pin <= 1'b0;
      o_rx_sync_pin_oe_n <= 1'b1;
    end
    else if (i_clk_en)
    begin
      o_rx_clock_pin <= next_clk_level;
      o_rx_clock_pin_oe_n <= ~next_clk_drive;
      // data and frame sync are always inputs in serial mode
      o_rx_data_pin <= pinctl[SPRT_PIN_DATA].dat_out;
      o_rx_data_pin_oe_n <=
        pinctl[SPRT_PIN_DATA].func_sel | ~pinctl[SPRT_PIN_DATA].dir;
      o_rx_sync_pin <= pinctl[SPRT_PIN_SYNC].dat_out;
      o_rx_sync_pin_oe_n <=
        pinctl[SPRT_PIN_SYNC].func_sel | ~pinctl[SPRT_PIN_SYNC].dir;
    end
  end

  // ---------------------------------------------------------------
  // timer control, period and timers
  // ---------------------------------------------------------------
  generate
    for (genvar t = 0; t < SPRT_NUM_TIMERS; t++)
    begin : g_tim
      localparam int B = t * SPRT_TIM_FLD_W;
      localparam int H = t * SPRT_HALF_W;

      always_ff @(posedge i_clock)
      begin
        if (i_srst)
          timctl[t] <= sprt_tctl_t'(SPRT_RST_TIMCTL[B +: SPRT_TIM_FLD_W]);
        else if (i_clk_en)
        begin
          if (wr_timctl)
          begin
            timctl[t].run_n_hold <= i_wdata[B+1];
            timctl[t].clock_pulse_sel <= i_wdata[B+2];
            timctl[t].src_sel <= i_wdata[B+3];
          end
          // a fresh 1 wins over the self-clear; a written 0 is ignored
          if (wr_timctl && i_wdata[B])
            timctl[t].go <= 1'b1;
          else if (go_done[t])
            timctl[t].go <= 1'b0;
        end
      end

      always_ff @(posedge i_clock)
      begin
        if (i_srst)
          period[t] <= CNT_W'(SPRT_RST_WORD[H +: SPRT_HALF_W]);
        else if (i_clk_en && wr_period)
          period[t] <= CNT_W'(i_wdata[H +: SPRT_HALF_W]);
      end

      sprt_timer #(
        .CNT_W(CNT_W)
      ) u_timer (
        .i_clock(i_clock),
        .i_srst(i_srst),
        .i_clk_en(i_clk_en),
        .i_ctl(timctl[t]),
        .i_ext_clk(ext_clk[t]),
        .i_period(period[t]),
        .i_cnt_wr(wr_count),
        .i_cnt_wdata(CNT_W'(i_wdata[H +: SPRT_HALF_W])),
        .o_count(count[t]),
        .o_flag(flag[t]),
        .o_go_done(go_done[t]),
        .o_irq(irq[t])
      );

      always_comb
      begin
        tim_view[t] = timctl[t];
        tim_view[t].rsvd = 1'b0;
        tim_view[t].flag = flag[t];
      end
    end
  endgenerate

  // timer outputs straight from the timer flops
  always_comb
  begin
    o_tx_timer_out = flag[SPRT_TX];
    o_tx_timer_irq = irq[SPRT_TX];
    o_rx_timer_irq = irq[SPRT_RX];
  end

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  // a read has no side effect, so a running timer may be polled freely
  always_comb
  begin
    next_rdata = '0;
    if (i_rd)
    begin
      if (reg_hit(i_addr, SPRT_OFS_PINCTL))
        next_rdata = 32'(pinctl);
      else if (reg_hit(i_addr, SPRT_OFS_TIMCTL))
        next_rdata = 32'(tim_view);
      else if (reg_hit(i_addr, SPRT_OFS_COUNT))
        next_rdata = {widen(count[SPRT_RX]), widen(count[SPRT_TX])};
      else if (reg_hit(i_addr, SPRT_OFS_PERIOD))
        next_rdata = {widen(period[SPRT_RX]), widen(period[SPRT_TX])};
    end
  end

  // data stand only in the cycle after the read strobe
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
      o_rdata <= '0;
    else if (i_clk_en)
      o_rdata <= next_rdata;
  end

endmodule : sprt_top
`default_nettype wire

// File: shared/sprt_pkg.sv
`default_nettype none
package sprt_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam int SPRT_ADDR_W = 8;
  localparam logic [7:0] SPRT_OFS_PINCTL = 8'h00;
  localparam logic [7:0] SPRT_OFS_TIMCTL = 8'h04;
  localparam logic [7:0] SPRT_OFS_COUNT = 8'h08;
  localparam logic [7:0] SPRT_OFS_PERIOD = 8'h0C;

  // ---------------------------------------------------------------
  // field layout
  // ---------------------------------------------------------------
  localparam int SPRT_NUM_PINS = 3;
  localparam int SPRT_PIN_FLD_W = 4;
  localparam int SPRT_NUM_TIMERS = 2;
  localparam int SPRT_TIM_FLD_W = 6;
  localparam int SPRT_HALF_W = 16;
  localparam int SPRT_CNT_W = 16;
  localparam int SPRT_SYNC_W = 4;
  localparam int SPRT_TX = 0;
  localparam int SPRT_RX = 1;
  localparam int SPRT_PIN_CLK = 0;
  localparam int SPRT_PIN_DATA = 1;
  localparam int SPRT_PIN_SYNC = 2;
  localparam int SPRT_SYNC_TXCLK = 3;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [31:0] SPRT_RST_PINCTL = 32'h0000_0000;
  localparam logic [31:0] SPRT_RST_TIMCTL = 32'h0000_0000;
  localparam logic [31:0] SPRT_RST_WORD = 32'h0000_0000;

  // one pin field, bit 0 first: func_sel, dir, out, in
  typedef struct packed {
    logic dat_in;
    logic dat_out;
    logic dir;
    logic func_sel;
  } sprt_pin_t;

  // one timer field, bit 0 first: go, run_n_hold, clock_pulse, src
  typedef struct packed {
    logic flag;
    logic rsvd;
    logic src_sel;
    logic clock_pulse_sel;
    logic run_n_hold;
    logic go;
  } sprt_tctl_t;

endpackage : sprt_pkg
`default_nettype wire
